/* src/vss_sequencer.sv */
// Purpose: enable qualification, soft-start ramp and on-the-fly voltage-code tracking
// Assumes: sw_tick_i marks each switching cycle, slot_tick_i six times per cycle
// Notes:   reference leaves as a 12.5mV unit count for the reference converter

module vss_sequencer #(
  parameter int unsigned REF_W = 8
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             sw_tick_i,
  input  wire logic             slot_tick_i,
  input  wire logic             por_ok_i,
  input  wire logic             thr_en_i,
  input  wire logic             logic_level_gate_i,
  input  wire logic [5:0]       voltage_code_i,
  input  wire logic             ov_trip_i,
  input  wire logic             out_at_ref_i,
  input  wire logic             in_window_i,
  output logic                  pwm_drive_en_o,
  output logic                  pwm_force_low_o,
  output logic [REF_W-1:0]      ref_units_o,
  output logic [9:0]            sense_offset_o,
  output logic [1:0]            ov_level_o,
  output logic                  output_ok_flag_o,
  output logic                  ss_active_o
);

  // ==========================================================================
  // helper functions

  // code to reference level; the two no-load codes read as zero
  function automatic logic [REF_W-1:0] code_units(input logic [5:0] code);
    logic [7:0] u;
    u = 8'h00;
    if (code == vss_pkg::CODE_OFF_A || code == vss_pkg::CODE_OFF_B) begin
      u = 8'h00;
    end else if (code <= vss_pkg::CODE_SPLIT) begin
      u = vss_pkg::LOW_BAND_BASE - {2'b00, code};
    end else begin
      u = vss_pkg::HIGH_BAND_BASE - {2'b00, code};
    end
    return REF_W'(u);
  endfunction

  // move ref toward tgt by amt units without overshoot
  function automatic logic [REF_W-1:0] step_ref(input logic [REF_W-1:0] cur,
                                                input logic [REF_W-1:0] tgt,
                                                input logic [1:0]       amt);
    logic [REF_W-1:0] gap;
    logic [REF_W-1:0] a;
    gap = (cur < tgt) ? (tgt - cur) : (cur - tgt);
    a   = (REF_W'(amt) < gap) ? REF_W'(amt) : gap;
    return (cur < tgt) ? (cur + a) : (cur - a);
  endfunction

  // ==========================================================================
  // declarations
  vss_pkg::vss_state_e state_reg, state_next;
  logic             por_meta_reg, por_sync_reg;
  logic             thr_meta_reg, thr_sync_reg;
  logic [1:0]       nocode_cnt_reg, nocode_cnt_next;
  logic             nocode_reg, nocode_next;
  logic             ov_latch_reg, ov_latch_next;
  logic [11:0]      cyc_cnt_reg, cyc_cnt_next;
  logic [REF_W-1:0] ref_reg, ref_next;
  logic [REF_W-1:0] tgt_reg, tgt_next;
  logic [5:0]       code_last_reg;
  logic [1:0]       wait_reg, wait_next;
  logic             dir_up_reg, dir_up_next;
  logic             pwm_live_reg, pwm_live_next;
  logic             drive_next;
  logic             force_low_next;
  logic [9:0]       offset_next;
  logic [1:0]       ovl_next;
  logic             ok_next;

  // ==========================================================================
  // enable qualification
  wire code_off   = (voltage_code_i == vss_pkg::CODE_OFF_A) ||
                    (voltage_code_i == vss_pkg::CODE_OFF_B);
  wire pins_en    = por_sync_reg & thr_sync_reg & logic_level_gate_i;
  wire en_all     = pins_en & ~nocode_reg;
  wire in_ramp    = (state_reg == vss_pkg::VSS_RAMP);
  wire in_run     = (state_reg == vss_pkg::VSS_RUN);
  wire delay_done = sw_tick_i && (cyc_cnt_reg == vss_pkg::SS_DELAY_LAST);
  wire fast_phase = (cyc_cnt_reg < vss_pkg::SS_FAST_CYC);
  wire code_chg   = slot_tick_i && (voltage_code_i != code_last_reg) && !code_off;
  wire want_up    = (tgt_reg > ref_reg);
  wire want_dn    = (tgt_reg < ref_reg);
  wire ramp_step  = sw_tick_i && (fast_phase ?
                    ((cyc_cnt_reg & vss_pkg::FAST_STEP_MASK) == vss_pkg::FAST_STEP_MASK) :
                    ((cyc_cnt_reg & vss_pkg::SLOW_STEP_MASK) == vss_pkg::SLOW_STEP_MASK));

  // ==========================================================================
  // two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      por_meta_reg <= 1'b0;
      por_sync_reg <= 1'b0;
      thr_meta_reg <= 1'b0;
      thr_sync_reg <= 1'b0;
    end else begin
      por_meta_reg <= por_ok_i;
      por_sync_reg <= por_meta_reg;
      thr_meta_reg <= thr_en_i;
      thr_sync_reg <= thr_meta_reg;
    end
  end

  // ==========================================================================
  // no-load code filter: shutdown only on the second switching tick seen while the code is held
  always_comb begin
    nocode_cnt_next = nocode_cnt_reg;
    nocode_next     = nocode_reg;
    if (!code_off) begin
      nocode_cnt_next = 2'h0;
      nocode_next     = 1'b0;
    end else if (sw_tick_i && nocode_cnt_reg != vss_pkg::NOCODE_DELAY) begin
      nocode_cnt_next = nocode_cnt_reg + 2'h1;
      nocode_next     = (nocode_cnt_reg + 2'h1) == vss_pkg::NOCODE_DELAY;
    end
  end

  // ==========================================================================
  // overvoltage latch; a new trip wins over the clear in the same cycle
  always_comb begin
    if (ov_trip_i && por_sync_reg) begin
      ov_latch_next = 1'b1;
    end else if (!pins_en) begin
      ov_latch_next = 1'b0;
    end else begin
      ov_latch_next = ov_latch_reg;
    end
  end

  // ==========================================================================
  // sequencer state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      vss_pkg::VSS_SHUT: begin
        if (en_all && !ov_latch_reg) begin
          state_next = vss_pkg::VSS_DELAY;
        end
      end
      vss_pkg::VSS_DELAY: begin
        if (delay_done) begin
          state_next = vss_pkg::VSS_RAMP;
        end
      end
      vss_pkg::VSS_RAMP: begin
        if (ref_reg == tgt_reg && ref_reg != '0) begin
          state_next = vss_pkg::VSS_RUN;
        end
      end
      vss_pkg::VSS_RUN: begin
        state_next = vss_pkg::VSS_RUN;
      end
      vss_pkg::VSS_OVP: begin
        if (!ov_latch_reg) begin
          state_next = vss_pkg::VSS_SHUT;
        end
      end
      default: begin
        state_next = vss_pkg::VSS_SHUT;
      end
    endcase
    // the latch outranks every enable; codes alone cannot leave it
    if (ov_latch_reg) begin
      state_next = vss_pkg::VSS_OVP;
    end else if (!en_all && state_reg != vss_pkg::VSS_OVP) begin
      state_next = vss_pkg::VSS_SHUT;
    end
  end

  // ==========================================================================
  // cycle counter, restarted on each state change
  always_comb begin
    if (state_next != state_reg) begin
      cyc_cnt_next = 12'h000;
    end else if (sw_tick_i && cyc_cnt_reg != 12'hfff) begin
      cyc_cnt_next = cyc_cnt_reg + 12'h001;
    end else begin
      cyc_cnt_next = cyc_cnt_reg;
    end
  end

  // ==========================================================================
  // reference: soft-start ramp and on-the-fly tracking
  always_comb begin
    ref_next    = ref_reg;
    wait_next   = wait_reg;
    dir_up_next = dir_up_reg;
    tgt_next    = code_off ? tgt_reg : code_units(voltage_code_i);
    case (state_reg)
      vss_pkg::VSS_RAMP: begin
        if (ramp_step) begin
          // coarse steps keep the 1280 cycles per volt rate at half the resolution
          ref_next = step_ref(ref_reg, tgt_reg, fast_phase ?
                              vss_pkg::FAST_STEP_UNITS :
                              vss_pkg::SLOW_STEP_UNITS);
        end
      end
      vss_pkg::VSS_RUN: begin
        // a further change inside the wait re-arms it, so the waited step always
        // aims at the newest code; the direction test still blocks a step whose
        // sign no longer matches the request
        if (code_chg) begin
          wait_next   = vss_pkg::HALF_CYC_SLOTS;
          dir_up_next = code_units(voltage_code_i) > ref_reg;
        end else if (slot_tick_i && wait_reg != 2'h0) begin
          wait_next = wait_reg - 2'h1;
          if (wait_reg == 2'h1 && (dir_up_reg ? want_up : want_dn)) begin
            ref_next = step_ref(ref_reg, tgt_reg, vss_pkg::SLOW_STEP_UNITS);
          end
        end else if (slot_tick_i && wait_reg == 2'h0 && tgt_reg != ref_reg) begin
          // out-of-step requests are chased once per slot, six per cycle
          ref_next = step_ref(ref_reg, tgt_reg, vss_pkg::SLOW_STEP_UNITS);
        end
      end
      default: begin
        ref_next  = '0;
        wait_next = 2'h0;
      end
    endcase
  end

  // ==========================================================================
  // phase drive qualification
  always_comb begin
    pwm_live_next = pwm_live_reg;
    if (!(in_ramp || in_run)) begin
      pwm_live_next = 1'b0;
    end else if (out_at_ref_i) begin
      pwm_live_next = 1'b1;
    end
  end

  // ==========================================================================
  // registered output values
  wire ovp_next  = (state_next == vss_pkg::VSS_OVP);
  wire live_next = (state_next == vss_pkg::VSS_RAMP || state_next == vss_pkg::VSS_RUN);
  always_comb begin
    force_low_next = ovp_next && ov_trip_i;
    drive_next     = force_low_next || (live_next && pwm_live_next);
    case (state_next)
      vss_pkg::VSS_DELAY: offset_next = vss_pkg::OFFSET_FULL;
      vss_pkg::VSS_RAMP: begin
        offset_next = (cyc_cnt_next < vss_pkg::SS_FAST_CYC) ?
                      (vss_pkg::OFFSET_FULL - cyc_cnt_next[9:0]) : 10'h000;
      end
      default: offset_next = 10'h000;
    endcase
    case (state_next)
      vss_pkg::VSS_DELAY, vss_pkg::VSS_RAMP: ovl_next = vss_pkg::VSS_OVL_SS;
      vss_pkg::VSS_RUN, vss_pkg::VSS_OVP:    ovl_next = vss_pkg::VSS_OVL_CODE;
      default:                               ovl_next = vss_pkg::VSS_OVL_SHUT;
    endcase
    ok_next = (state_next == vss_pkg::VSS_RUN) && in_window_i;
  end

  // ==========================================================================
  // state registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg      <= vss_pkg::VSS_SHUT;
      nocode_cnt_reg <= 2'h0;
      nocode_reg     <= 1'b0;
      ov_latch_reg   <= 1'b0;
      cyc_cnt_reg    <= 12'h000;
      ref_reg        <= '0;
      tgt_reg        <= '0;
      code_last_reg  <= 6'h00;
      wait_reg       <= 2'h0;
      dir_up_reg     <= 1'b0;
      pwm_live_reg   <= 1'b0;
    end else begin
      state_reg      <= state_next;
      nocode_cnt_reg <= nocode_cnt_next;
      nocode_reg     <= nocode_next;
      ov_latch_reg   <= ov_latch_next;
      cyc_cnt_reg    <= cyc_cnt_next;
      ref_reg        <= ref_next;
      tgt_reg        <= tgt_next;
      wait_reg       <= wait_next;
      dir_up_reg     <= dir_up_next;
      pwm_live_reg   <= pwm_live_next;
      if (slot_tick_i) begin
        code_last_reg <= voltage_code_i;
      end
    end
  end

  // ==========================================================================
  // output registers; drive low by default so phases float at reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pwm_drive_en_o   <= 1'b0;
      pwm_force_low_o  <= 1'b0;
      ref_units_o      <= '0;
      sense_offset_o   <= 10'h000;
      ov_level_o       <= vss_pkg::VSS_OVL_SHUT;
      output_ok_flag_o <= 1'b0;
      ss_active_o      <= 1'b0;
    end else begin
      pwm_drive_en_o   <= drive_next;
      pwm_force_low_o  <= force_low_next;
      ref_units_o      <= ref_next;
      sense_offset_o   <= offset_next;
      ov_level_o       <= ovl_next;
      output_ok_flag_o <= ok_next;
      ss_active_o      <= (state_next == vss_pkg::VSS_DELAY) ||
                          (state_next == vss_pkg::VSS_RAMP);
    end
  end

endmodule // vss_sequencer

/* inc/vss_pkg.sv */
// Purpose: shared constants and types of the voltage-code soft-start sequencer
// Assumes: reference held in 12.5mV units; time counted in switching cycles
// Notes:   every figure used by the sequencer lives here

package vss_pkg;

  // ==========================================================================
  // clock
  localparam int unsigned CLK_PERIOD_NS = 8;

  // ==========================================================================
  // switching-cycle timing
  localparam logic [2:0] SLOTS_PER_CYC  = 3'h6;   // code samples per switching cycle
  localparam logic [1:0] HALF_CYC_SLOTS = 2'h3;   // half a cycle in sample slots
  localparam logic [1:0] NOCODE_DELAY   = 2'h2;   // cycles before no-load shutdown acts

  // ==========================================================================
  // soft-start timing
  localparam int unsigned SS_CYC_PER_VOLT = 1280;
  localparam int unsigned UNITS_PER_VOLT  = 80;   // 12.5mV units in one volt
  localparam int unsigned SS_CYC_PER_UNIT = SS_CYC_PER_VOLT / UNITS_PER_VOLT;
  localparam logic [11:0] SS_DELAY_LAST   = 12'h03f;  // 64 cycles, counted from zero
  localparam logic [11:0] SS_FAST_CYC     = 12'h280;  // 640 cycles of coarse steps
  localparam logic [11:0] SLOW_STEP_MASK  = 12'(SS_CYC_PER_UNIT - 1);
  localparam logic [11:0] FAST_STEP_MASK  = 12'(2 * SS_CYC_PER_UNIT - 1);
  localparam logic [1:0]  FAST_STEP_UNITS = 2'h2;     // 25mV
  localparam logic [1:0]  SLOW_STEP_UNITS = 2'h1;     // 12.5mV
  localparam logic [9:0]  OFFSET_FULL     = 10'h280;  // 100mV offset as 640 counts

  // ==========================================================================
  // voltage code decode
  localparam logic [5:0] CODE_OFF_A     = 6'h3f;
  localparam logic [5:0] CODE_OFF_B     = 6'h3e;
  localparam logic [5:0] CODE_SPLIT     = 6'h14;   // last code of the low band
  localparam logic [7:0] LOW_BAND_BASE  = 8'h57;   // code 000000 is 87 units
  localparam logic [7:0] HIGH_BAND_BASE = 8'h95;   // 149 units minus code

  // ==========================================================================
  // sequencer states and overvoltage trip levels
  typedef enum logic [2:0] {
    VSS_SHUT  = 3'b000,
    VSS_DELAY = 3'b001,
    VSS_RAMP  = 3'b010,
    VSS_RUN   = 3'b011,
    VSS_OVP   = 3'b100
  } vss_state_e;

  typedef enum logic [1:0] {
    VSS_OVL_SHUT = 2'b00,   // fixed shutdown trip level
    VSS_OVL_SS   = 2'b01,   // higher of fixed level and code plus margin
    VSS_OVL_CODE = 2'b10    // code plus margin
  } vss_ovl_e;

endpackage : vss_pkg

/* verif/vss_seq_properties.sv */
// Purpose: port-level assertions for the voltage-code soft-start sequencer
// Assumes: one clock domain, synchronous active-high reset
// Notes:   attached to every sequencer instance by the bind at the foot
module vss_seq_chk #(
  parameter int unsigned REF_W = 8
) (
  input wire logic             clk_i,
  input wire logic             srst_i,
  input wire logic             sw_tick_i,
  input wire logic             slot_tick_i,
  input wire logic             por_ok_i,
  input wire logic             thr_en_i,
  input wire logic             logic_level_gate_i,
  input wire logic [5:0]       voltage_code_i,
  input wire logic             ov_trip_i,
  input wire logic             out_at_ref_i,
  input wire logic             in_window_i,
  input wire logic             pwm_drive_en_o,
  input wire logic             pwm_force_low_o,
  input wire logic [REF_W-1:0] ref_units_o,
  input wire logic [9:0]       sense_offset_o,
  input wire logic [1:0]       ov_level_o,
  input wire logic             output_ok_flag_o,
  input wire logic             ss_active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // helpers
  // saturating count of switching ticks seen while a no-load code is held
  logic [1:0] off_cnt_reg;
  wire        code_off = (voltage_code_i == 6'h3f) || (voltage_code_i == 6'h3e);
  // reference the present code asks for, in 12.5mV units
  wire  [7:0] code_units = (voltage_code_i <= 6'h14) ? 8'h57 - 8'(voltage_code_i)
                                                     : 8'h95 - 8'(voltage_code_i);
  always_ff @(posedge clk_i) begin
    if (srst_i || !code_off) begin
      off_cnt_reg <= 2'h0;
    end else if (sw_tick_i && off_cnt_reg != 2'h3) begin
      off_cnt_reg <= off_cnt_reg + 2'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // overvoltage needs a settled supply before the latch may act
  sequence s_por_held;
    por_ok_i [*4];
  endsequence
  sequence s_trip_held;
    ov_trip_i [*2];
  endsequence

  // ====================
  // assertions
  chk_shut_hiz: assert property (
    !logic_level_gate_i && !ov_trip_i |=> !pwm_drive_en_o && !ss_active_o)
    else $error("phases driven with gate low");
  chk_start_cond: assert property (
    $rose(ss_active_o) |-> $past(por_ok_i, 3) && $past(thr_en_i, 3)
      && $past(logic_level_gate_i) && !$past(code_off))
    else $error("soft-start without all enables");
  chk_ss_entry: assert property (
    $rose(ss_active_o) |-> ref_units_o == '0 && sense_offset_o == 10'h280 && !pwm_drive_en_o)
    else $error("soft-start entry values wrong");
  chk_ramp_step: assert property (
    ss_active_o && $past(ss_active_o) && ref_units_o != $past(ref_units_o)
      |-> $past(sw_tick_i) && ((ref_units_o - $past(ref_units_o)) inside {REF_W'(1), REF_W'(2)}))
    else $error("ramp step size or moment wrong");
  chk_offset_fall: assert property (
    ss_active_o && $past(ss_active_o) && sense_offset_o != $past(sense_offset_o)
      |-> $past(sw_tick_i) && sense_offset_o == $past(sense_offset_o) - 10'h1)
    else $error("sense offset not falling by one");
  chk_run_target: assert property (
    $fell(ss_active_o) && ov_level_o == 2'h2 && !ov_trip_i |-> ref_units_o == REF_W'(code_units))
    else $error("ramp ended off target");
  chk_track_step: assert property (
    !ss_active_o && ov_level_o == 2'h2 && $past(ov_level_o) == 2'h2
      && ref_units_o != $past(ref_units_o) |-> $past(slot_tick_i)
      && (ref_units_o == $past(ref_units_o) + REF_W'(1)
          || ref_units_o == $past(ref_units_o) - REF_W'(1)))
    else $error("tracking step wrong");
  chk_ok_cause: assert property (
    output_ok_flag_o |-> $past(in_window_i) && !ss_active_o && ov_level_o == 2'h2)
    else $error("output ok outside run");
  chk_nocode_shut: assert property (
    off_cnt_reg == 2'h3 && !ov_trip_i |-> !ss_active_o && !output_ok_flag_o && !pwm_drive_en_o)
    else $error("no-load code did not shut down");
  chk_ovp_force: assert property (
    s_por_held ##0 s_trip_held |=> pwm_force_low_o && pwm_drive_en_o && ov_level_o == 2'h2)
    else $error("overvoltage did not force phases low");
  chk_force_cause: assert property (
    pwm_force_low_o |-> $past(ov_trip_i))
    else $error("phases forced low without overvoltage");
endmodule // vss_seq_chk

bind vss_sequencer vss_seq_chk #(.REF_W(REF_W)) u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .sw_tick_i(sw_tick_i), .slot_tick_i(slot_tick_i),
  .por_ok_i(por_ok_i), .thr_en_i(thr_en_i), .logic_level_gate_i(logic_level_gate_i),
  .voltage_code_i(voltage_code_i), .ov_trip_i(ov_trip_i), .out_at_ref_i(out_at_ref_i),
  .in_window_i(in_window_i), .pwm_drive_en_o(pwm_drive_en_o), .pwm_force_low_o(pwm_force_low_o),
  .ref_units_o(ref_units_o), .sense_offset_o(sense_offset_o), .ov_level_o(ov_level_o),
  .output_ok_flag_o(output_ok_flag_o), .ss_active_o(ss_active_o));

/* verif/vss_cpu_model.sv */
// Purpose: processor model that supplies voltage codes and the code-valid level
// Assumes: codes change on the rising edge, one clock after the request
// Notes:   step mode walks one code per PACE clocks, otherwise codes jump
module vss_cpu_model #(
  parameter int unsigned PACE = 24
) (
  input  wire logic       clk_i,
  input  wire logic [5:0] code_req_i,
  input  wire logic       valid_req_i,
  input  wire logic       step_mode_i,
  output logic [5:0]      voltage_code_o,
  output logic            cpu_code_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned pace_cnt = 0;
  initial begin
    voltage_code_o = 6'h14;
    cpu_code_valid_o = 1'b0;
  end
  // paced single-code walk keeps each change to one 12.5mV step inside a band
  always @(posedge clk_i) begin
    cpu_code_valid_o <= valid_req_i;
    pace_cnt <= (pace_cnt == PACE - 1) ? 0 : pace_cnt + 1;
    if (!step_mode_i) begin
      voltage_code_o <= code_req_i;
    end else if (pace_cnt == 0 && voltage_code_o < code_req_i) begin
      voltage_code_o <= voltage_code_o + 6'h1;
    end else if (pace_cnt == 0 && voltage_code_o > code_req_i) begin
      voltage_code_o <= voltage_code_o - 6'h1;
    end
  end
endmodule // vss_cpu_model

/* verif/tb_top.sv */
// Purpose: self-checking bench for the voltage-code soft-start sequencer
// Assumes: sample tick every 2 clocks, switching tick every 12 clocks
// Notes:   a full soft-start to code 14 takes about 1136 switching cycles
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // signals
  logic       clk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic       sw_tick_i = 1'b0;
  logic       slot_tick_i = 1'b0;
  logic       por_ok_i = 1'b0;
  logic       thr_en_i = 1'b0;
  logic       ov_trip_i = 1'b0;
  logic       out_at_ref_i = 1'b0;
  logic       in_window_i = 1'b1;
  logic [5:0] code_req = 6'h14;
  logic       valid_req = 1'b0;
  logic       step_mode = 1'b0;
  logic [5:0] voltage_code;
  logic       code_valid, drive_en, force_low, ok_flag, ss_active;
  logic [7:0] ref_units;
  logic [9:0] offset;
  logic [1:0] ov_level;
  int         tick_cnt = 0;
  int         sw_count = 0;
  int         s0 = 0;
  int         miscompares = 0;
  int         checks = 0;

  always #(vss_pkg::CLK_PERIOD_NS / 2) clk_i = ~clk_i;
  // ticks move just after the edge, like the inputs the bench drives directly
  always @(posedge clk_i) begin
    #1;
    tick_cnt = (tick_cnt == 11) ? 0 : tick_cnt + 1;
    slot_tick_i = (tick_cnt % 2 == 0);
    sw_tick_i = (tick_cnt == 0);
    sw_count = sw_count + int'(sw_tick_i);
  end

  vss_sequencer #(.REF_W(8)) u_dut (
    .clk_i(clk_i), .srst_i(srst_i), .sw_tick_i(sw_tick_i), .slot_tick_i(slot_tick_i),
    .por_ok_i(por_ok_i), .thr_en_i(thr_en_i), .logic_level_gate_i(code_valid),
    .voltage_code_i(voltage_code), .ov_trip_i(ov_trip_i), .out_at_ref_i(out_at_ref_i),
    .in_window_i(in_window_i), .pwm_drive_en_o(drive_en), .pwm_force_low_o(force_low),
    .ref_units_o(ref_units), .sense_offset_o(offset), .ov_level_o(ov_level),
    .output_ok_flag_o(ok_flag), .ss_active_o(ss_active));
  vss_cpu_model u_cpu (
    .clk_i(clk_i), .code_req_i(code_req), .valid_req_i(valid_req), .step_mode_i(step_mode),
    .voltage_code_o(voltage_code), .cpu_code_valid_o(code_valid));

  // ====================
  // shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic clocks(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_ss(input logic v, input int lim);
    for (int n = 0; n < lim && ss_active !== v; n++) clocks(1);
  endtask
  task automatic wait_ref(input logic [7:0] v, input int lim);
    for (int n = 0; n < lim && ref_units !== v; n++) clocks(1);
  endtask
  task automatic wait_sw(input int n);
    while (sw_count < n) clocks(1);
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ====================
  // scenarios
  task automatic t_enables();
    for (int i = 0; i < 3; i++) begin
      por_ok_i = (i != 0);
      thr_en_i = (i != 1);
      valid_req = (i != 2);
      clocks(40);
      check(16'(ss_active), 16'h0, "started with an enable low");
      check(16'(drive_en), 16'h0, "phases driven in shutdown");
    end
    valid_req = 1'b1;
    wait_ss(1'b1, 6);
    check(16'(ss_active), 16'h1, "slow start");
    check(16'(offset), 16'h280, "entry offset");
    check(16'(ref_units), 16'h0, "entry reference");
    $display("done: enable gating");
  endtask
  task automatic t_nocode_delay();
    wait_sw(sw_count + 1);
    code_req = 6'h3e;
    clocks(14);
    check(16'(ss_active), 16'h1, "no-load acted early");
    clocks(24);
    check(16'(ss_active), 16'h0, "no-load ignored");
    check(16'(ov_level), 16'h0, "trip level not at shutdown");
    code_req = 6'h14;
    wait_ss(1'b1, 8);
    check(16'(ss_active), 16'h1, "no restart on valid code");
    $display("done: no-load code in delay");
  endtask
  task automatic t_ovp();
    ov_trip_i = 1'b1;
    clocks(3);
    check(16'(force_low), 16'h1, "phases not forced low");
    ov_trip_i = 1'b0;
    clocks(3);
    check(16'(force_low), 16'h0, "phases still forced");
    code_req = 6'h3f;
    clocks(40);
    code_req = 6'h14;
    clocks(40);
    check(16'(ss_active), 16'h0, "codes cleared the latch");
    valid_req = 1'b0;
    clocks(4);
    valid_req = 1'b1;
    wait_ss(1'b1, 8);
    check(16'(ss_active), 16'h1, "gate cycle kept the latch");
    $display("done: overvoltage latch");
  endtask
  task automatic t_ramp();
    s0 = sw_count;
    wait_sw(s0 + 60);
    check(16'(ref_units), 16'h0, "ramp inside the delay");
    wait_sw(s0 + 384);
    check(16'(ref_units >= 8'h12 && ref_units <= 8'h16), 16'h1, "coarse ramp rate");
    check(16'(offset >= 10'h13e && offset <= 10'h142), 16'h1, "offset decay");
    check(16'(drive_en), 16'h0, "phases on below output");
    out_at_ref_i = 1'b1;
    clocks(3);
    check(16'(drive_en), 16'h1, "phases off at output");
    wait_ss(1'b0, 15000);
    check(16'(sw_count - s0 >= 1120 && sw_count - s0 <= 1150), 16'h1, "ramp length");
    check(16'(ref_units), 16'h43, "final reference");
    clocks(2);
    check(16'(ok_flag), 16'h1, "no output ok");
    in_window_i = 1'b0;
    clocks(3);
    check(16'(ok_flag), 16'h0, "ok outside window");
    in_window_i = 1'b1;
    $display("done: soft-start ramp");
  endtask
  task automatic t_track();
    step_mode = 1'b1;
    code_req = 6'h10;
    wait_ref(8'h47, 150);
    check(16'(ref_units), 16'h47, "single steps not followed");
    step_mode = 1'b0;
    clocks(12);
    code_req = 6'h11;
    clocks(2);
    code_req = 6'h0f;
    // a step down would betray a missed reversal
    for (int i = 0; i < 30; i++) begin
      clocks(1);
      if (ref_units === 8'h46) check(16'(ref_units), 16'h48, "stepped after reversal");
    end
    check(16'(ref_units), 16'h48, "reversed code not reached");
    code_req = 6'h0b;
    wait_ref(8'h4c, 30);
    check(16'(ref_units), 16'h4c, "large change tracked slowly");
    $display("done: code tracking");
  endtask
  task automatic t_nocode_run();
    code_req = 6'h3f;
    clocks(40);
    check(16'(ok_flag), 16'h0, "ok kept after no-load");
    check(16'(drive_en), 16'h0, "phases driven after no-load");
    $display("done: no-load code in run");
  endtask

  // ====================
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    srst_i = 1'b0;
    t_enables();
    t_nocode_delay();
    t_ovp();
    t_ramp();
    t_track();
    t_nocode_run();
    results();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    results();
  end
endmodule // tb_top
